// *** ucip_pkg.sv ***
// Constants, types and helper functions for the serial port control slice
package ucip_pkg;

    // ==========================================================
    // Register offsets (byte addresses on the APB)
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_DATA = 12'h000;
    localparam logic [11:0] OFF_FLAGS = 12'h018;
    localparam logic [11:0] OFF_LINE_CTRL = 12'h02c;
    localparam logic [11:0] OFF_CTRL = 12'h030;
    localparam logic [11:0] OFF_TRIG = 12'h034;
    localparam logic [11:0] OFF_MASK = 12'h038;
    localparam logic [11:0] OFF_RAW = 12'h03c;
    localparam logic [11:0] OFF_MIS = 12'h040;
    localparam logic [11:0] OFF_ICR = 12'h044;

    // ==========================================================
    // Field positions and reset values
    localparam int LC_BREAK_BIT = 0;
    localparam int LC_PARITY_ON_BIT = 1;
    localparam int LC_EVEN_BIT = 2;
    localparam logic [2:0] LC_RESET = 3'h0;
    localparam int CTL_PORT_ON_BIT = 0;
    localparam int CTL_LOOP_BIT = 7;
    localparam int CTL_TX_ON_BIT = 8;
    localparam int CTL_RX_ON_BIT = 9;
    localparam logic [9:0] CTL_WMASK = 10'h381;
    localparam logic [9:0] CTL_RESET = 10'h300;
    localparam int TRIG_TX_LSB = 0;
    localparam int TRIG_RX_LSB = 3;
    localparam logic [5:0] TRIG_RESET = 6'h12;
    localparam int IRQ_LSB = 4;
    localparam int IRQ_RX = 0;
    localparam int IRQ_TX = 1;
    localparam int IRQ_RT = 2;
    localparam int IRQ_FE = 3;
    localparam int IRQ_PE = 4;
    localparam int IRQ_BE = 5;
    localparam int IRQ_OE = 6;
    localparam logic [6:0] IRQ_RESET = 7'h00;
    localparam int FLG_BUSY = 3;
    localparam int FLG_RX_EMPTY = 4;
    localparam int FLG_TX_FULL = 5;
    localparam int FLG_RX_FULL = 6;
    localparam int FLG_TX_EMPTY = 7;

    // ==========================================================
    // Timing: one bit period in pclk cycles
    localparam int CLK_HZ = 25_000_000;
    localparam int BAUD_RATE = 115_200;
    localparam logic [11:0] BIT_CYCLES = 12'(CLK_HZ / BAUD_RATE);
    localparam logic [11:0] HALF_BIT = 12'(CLK_HZ / BAUD_RATE / 2);
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ==========================================================
    // Frame state machines
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} ucip_tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} ucip_rx_state_t;

    // Parity bit that makes data plus parity even or odd
    function automatic logic ucip_parity(input logic [7:0] data, input logic even);
        ucip_parity = even ? (^data) : ~(^data);
    endfunction

    // Trigger point for a 16-deep FIFO: {valid, level}; reserved codes are invalid
    function automatic logic [5:0] ucip_trig_point(input logic [2:0] code);
        case (code)
            3'h0: ucip_trig_point = 6'h22;
            3'h1: ucip_trig_point = 6'h24;
            3'h2: ucip_trig_point = 6'h28;
            3'h3: ucip_trig_point = 6'h2c;
            3'h4: ucip_trig_point = 6'h2e;
            default: ucip_trig_point = 6'h00;
        endcase
    endfunction

endpackage

// *** ucip_core.sv ***
// Serial port control, parity, break and interrupt status slice with APB access
`timescale 1ns/1ps
`default_nettype none

module ucip_core (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial pins
    output logic serial_tx_pin,
    input wire logic serial_rx_pin,
    // Fill levels and timeout event from the surrounding FIFO logic
    input wire logic [4:0] tx_fifo_level,
    input wire logic [4:0] rx_fifo_level,
    input wire logic rx_timeout_pulse,
    // Masked interrupt lines towards the interrupt controller, bits 10..4
    output logic [6:0] irq_lines
);

    // ==========================================================
    // Register state
    logic [2:0] line_ctrl_reg, line_ctrl_next;
    logic [9:0] ctrl_reg, ctrl_next;
    logic [5:0] trig_reg, trig_next;
    logic [6:0] mask_reg, mask_next;
    logic [6:0] raw_reg, raw_next;
    logic [7:0] tx_hold_reg, tx_hold_next;
    logic tx_full_reg, tx_full_next;
    logic [7:0] rx_data_reg, rx_data_next;
    logic rx_full_reg, rx_full_next;
    logic [4:0] tx_lvl_reg, rx_lvl_reg;
    logic [31:0] prdata_reg, prdata_next;
    logic pslverr_reg, pslverr_next;

    // Transmitter state
    ucip_pkg::ucip_tx_state_t tx_state_reg, tx_state_next;
    logic [11:0] tx_cnt_reg, tx_cnt_next;
    logic [3:0] tx_bit_reg, tx_bit_next;
    logic [7:0] tx_shift_reg, tx_shift_next;
    logic tx_line_reg, tx_line_next;

    // Receiver state
    ucip_pkg::ucip_rx_state_t rx_state_reg, rx_state_next;
    logic [11:0] rx_cnt_reg, rx_cnt_next;
    logic [3:0] rx_bit_reg, rx_bit_next;
    logic [7:0] rx_shift_reg, rx_shift_next;
    logic rx_perr_reg, rx_perr_next;
    logic rx_meta_reg, rx_sync_reg;

    // Decoded controls and events
    logic wr_en, rd_setup, rd_data_access;
    logic port_on, tx_section_on, rx_section_on, loopback_on;
    logic parity_on, even_parity_select, send_break_bit;
    logic rx_line;
    logic [6:0] set_evt, clr_evt;
    logic rx_done, rx_ferr, rx_brk;
    logic [5:0] rx_pt, tx_pt;

    assign wr_en = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign rd_data_access = psel & penable & ~pwrite & (paddr == ucip_pkg::OFF_DATA);
    assign port_on = ctrl_reg[ucip_pkg::CTL_PORT_ON_BIT];
    assign tx_section_on = ctrl_reg[ucip_pkg::CTL_TX_ON_BIT];
    assign rx_section_on = ctrl_reg[ucip_pkg::CTL_RX_ON_BIT];
    assign loopback_on = ctrl_reg[ucip_pkg::CTL_LOOP_BIT];
    assign parity_on = line_ctrl_reg[ucip_pkg::LC_PARITY_ON_BIT];
    assign even_parity_select = line_ctrl_reg[ucip_pkg::LC_EVEN_BIT];
    assign send_break_bit = line_ctrl_reg[ucip_pkg::LC_BREAK_BIT];

    // Zero wait states; read data and error are prepared in the setup cycle
    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    // Pin is held idle high during loopback so the far end sees nothing
    assign serial_tx_pin = loopback_on ? 1'b1 : tx_line_reg;
    assign rx_line = loopback_on ? tx_line_reg : rx_sync_reg;
    assign irq_lines = raw_reg & mask_reg;

    // ==========================================================
    // Pin synchroniser: the first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end else begin
            rx_meta_reg <= serial_rx_pin;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    // ==========================================================
    // Register file, read mux and interrupt status
    always_comb begin
        line_ctrl_next = line_ctrl_reg;
        ctrl_next = ctrl_reg;
        trig_next = trig_reg;
        mask_next = mask_reg;
        tx_hold_next = tx_hold_reg;
        tx_full_next = tx_full_reg;
        rx_data_next = rx_data_reg;
        rx_full_next = rx_full_reg;
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        clr_evt = 7'h00;
        rx_pt = ucip_pkg::ucip_trig_point(trig_reg[ucip_pkg::TRIG_RX_LSB +: 3]);
        tx_pt = ucip_pkg::ucip_trig_point(trig_reg[ucip_pkg::TRIG_TX_LSB +: 3]);
        // Events that hardware raises
        set_evt = 7'h00;
        set_evt[ucip_pkg::IRQ_RX] = rx_pt[5] && (rx_lvl_reg < rx_pt[4:0])
            && (rx_fifo_level >= rx_pt[4:0]);
        set_evt[ucip_pkg::IRQ_TX] = tx_pt[5] && (tx_lvl_reg > tx_pt[4:0])
            && (tx_fifo_level <= tx_pt[4:0]);
        set_evt[ucip_pkg::IRQ_RT] = rx_timeout_pulse;
        set_evt[ucip_pkg::IRQ_FE] = rx_done & rx_ferr;
        set_evt[ucip_pkg::IRQ_PE] = rx_done & rx_perr_reg;
        set_evt[ucip_pkg::IRQ_BE] = rx_done & rx_brk;
        set_evt[ucip_pkg::IRQ_OE] = rx_done & rx_full_reg & ~rd_data_access;
        if (wr_en) begin
            case (paddr)
                ucip_pkg::OFF_DATA: begin
                    tx_hold_next = pwdata[7:0];
                    tx_full_next = 1'b1;
                end
                ucip_pkg::OFF_LINE_CTRL: line_ctrl_next = pwdata[2:0];
                ucip_pkg::OFF_CTRL: ctrl_next = pwdata[9:0] & ucip_pkg::CTL_WMASK;
                ucip_pkg::OFF_TRIG: trig_next = pwdata[5:0];
                ucip_pkg::OFF_MASK: mask_next = pwdata[10:4];
                ucip_pkg::OFF_ICR: clr_evt = pwdata[10:4];
                default: ; // Raw, masked and flags ignore writes
            endcase
        end
        // A character completing in the read cycle is kept, not lost
        if (rd_data_access) begin
            rx_full_next = 1'b0;
        end
        if (rx_done) begin
            rx_data_next = rx_shift_reg;
            rx_full_next = 1'b1;
        end
        if (tx_state_reg == ucip_pkg::TX_IDLE && tx_state_next == ucip_pkg::TX_START) begin
            tx_full_next = 1'b0;
        end
        // Set wins over a clear in the same cycle
        raw_next = (raw_reg & ~clr_evt) | set_evt;
        if (rd_setup) begin
            prdata_next = 32'h0000_0000;
            case (paddr)
                ucip_pkg::OFF_DATA: prdata_next[7:0] = rx_data_reg;
                ucip_pkg::OFF_FLAGS: begin
                    prdata_next[ucip_pkg::FLG_BUSY] = tx_full_reg
                        | (tx_state_reg != ucip_pkg::TX_IDLE);
                    prdata_next[ucip_pkg::FLG_RX_EMPTY] = ~rx_full_reg;
                    prdata_next[ucip_pkg::FLG_TX_FULL] = tx_full_reg;
                    prdata_next[ucip_pkg::FLG_RX_FULL] = rx_full_reg;
                    prdata_next[ucip_pkg::FLG_TX_EMPTY] = ~tx_full_reg;
                end
                ucip_pkg::OFF_LINE_CTRL: prdata_next[2:0] = line_ctrl_reg;
                ucip_pkg::OFF_CTRL: prdata_next[9:0] = ctrl_reg;
                ucip_pkg::OFF_TRIG: prdata_next[5:0] = trig_reg;
                ucip_pkg::OFF_MASK: prdata_next[10:4] = mask_reg;
                ucip_pkg::OFF_RAW: prdata_next[10:4] = raw_reg;
                ucip_pkg::OFF_MIS: prdata_next[10:4] = raw_reg & mask_reg;
                ucip_pkg::OFF_ICR: ;
                default: pslverr_next = 1'b1;
            endcase
        end else if (psel & ~penable) begin
            pslverr_next = !(paddr == ucip_pkg::OFF_DATA || paddr == ucip_pkg::OFF_FLAGS
                || (paddr >= ucip_pkg::OFF_LINE_CTRL && paddr <= ucip_pkg::OFF_ICR
                && paddr[1:0] == 2'b00));
        end else if (psel) begin
            pslverr_next = pslverr_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_ctrl_reg <= ucip_pkg::LC_RESET;
            ctrl_reg <= ucip_pkg::CTL_RESET;
            trig_reg <= ucip_pkg::TRIG_RESET;
            mask_reg <= ucip_pkg::IRQ_RESET;
            raw_reg <= ucip_pkg::IRQ_RESET;
            tx_hold_reg <= 8'h00;
            tx_full_reg <= 1'b0;
            rx_data_reg <= 8'h00;
            rx_full_reg <= 1'b0;
            tx_lvl_reg <= 5'h00;
            rx_lvl_reg <= 5'h00;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            line_ctrl_reg <= line_ctrl_next;
            ctrl_reg <= ctrl_next;
            trig_reg <= trig_next;
            mask_reg <= mask_next;
            raw_reg <= raw_next;
            tx_hold_reg <= tx_hold_next;
            tx_full_reg <= tx_full_next;
            rx_data_reg <= rx_data_next;
            rx_full_reg <= rx_full_next;
            tx_lvl_reg <= tx_fifo_level;
            rx_lvl_reg <= rx_fifo_level;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // ==========================================================
    // Transmitter: each bit on the line lasts one bit period
    always_comb begin
        tx_state_next = tx_state_reg;
        tx_cnt_next = tx_cnt_reg;
        tx_bit_next = tx_bit_reg;
        tx_shift_next = tx_shift_reg;
        tx_line_next = tx_line_reg;
        if (tx_state_reg != ucip_pkg::TX_IDLE && tx_cnt_reg != 12'h000) begin
            tx_cnt_next = tx_cnt_reg - 12'h001;
        end else begin
            tx_cnt_next = ucip_pkg::BIT_CYCLES - 12'h001;
            case (tx_state_reg)
                ucip_pkg::TX_IDLE: begin
                    // Enables are looked at only between characters
                    if (send_break_bit) begin
                        tx_line_next = 1'b0;
                    end else if (port_on && tx_section_on && tx_full_reg) begin
                        tx_state_next = ucip_pkg::TX_START;
                        tx_shift_next = tx_hold_reg;
                        tx_line_next = 1'b0;
                    end else begin
                        tx_line_next = 1'b1;
                    end
                end
                ucip_pkg::TX_START: begin
                    tx_state_next = ucip_pkg::TX_DATA;
                    tx_bit_next = 4'h1;
                    tx_line_next = tx_shift_reg[0];
                end
                ucip_pkg::TX_DATA: begin
                    if (tx_bit_reg == ucip_pkg::DATA_BITS) begin
                        if (parity_on) begin
                            tx_state_next = ucip_pkg::TX_PARITY;
                            tx_line_next = ucip_pkg::ucip_parity(tx_hold_data(tx_shift_reg),
                                even_parity_select);
                        end else begin
                            tx_state_next = ucip_pkg::TX_STOP;
                            tx_line_next = 1'b1;
                        end
                    end else begin
                        tx_bit_next = tx_bit_reg + 4'h1;
                        tx_line_next = tx_shift_reg[tx_bit_reg[2:0]];
                    end
                end
                ucip_pkg::TX_PARITY: begin
                    tx_state_next = ucip_pkg::TX_STOP;
                    tx_line_next = 1'b1;
                end
                ucip_pkg::TX_STOP: begin
                    tx_state_next = ucip_pkg::TX_IDLE;
                    tx_line_next = ~send_break_bit;
                    tx_cnt_next = 12'h000;
                end
                default: tx_state_next = ucip_pkg::TX_IDLE;
            endcase
        end
    end

    // Shift register is not consumed, so the byte is its own parity source
    function automatic logic [7:0] tx_hold_data(input logic [7:0] shift);
        tx_hold_data = shift;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_reg <= ucip_pkg::TX_IDLE;
            tx_cnt_reg <= 12'h000;
            tx_bit_reg <= 4'h0;
            tx_shift_reg <= 8'h00;
            tx_line_reg <= 1'b1;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_cnt_reg <= tx_cnt_next;
            tx_bit_reg <= tx_bit_next;
            tx_shift_reg <= tx_shift_next;
            tx_line_reg <= tx_line_next;
        end
    end

    // ==========================================================
    // Receiver: start bit checked at mid-bit, then samples every bit period
    always_comb begin
        rx_state_next = rx_state_reg;
        rx_cnt_next = rx_cnt_reg;
        rx_bit_next = rx_bit_reg;
        rx_shift_next = rx_shift_reg;
        rx_perr_next = rx_perr_reg;
        rx_done = 1'b0;
        rx_ferr = 1'b0;
        rx_brk = 1'b0;
        if (rx_state_reg != ucip_pkg::RX_IDLE && rx_cnt_reg != 12'h000) begin
            rx_cnt_next = rx_cnt_reg - 12'h001;
        end else begin
            rx_cnt_next = ucip_pkg::BIT_CYCLES - 12'h001;
            case (rx_state_reg)
                ucip_pkg::RX_IDLE: begin
                    rx_cnt_next = ucip_pkg::HALF_BIT - 12'h001;
                    if (port_on && rx_section_on && !rx_line) begin
                        rx_state_next = ucip_pkg::RX_START;
                        rx_perr_next = 1'b0;
                    end
                end
                ucip_pkg::RX_START: begin
                    // A glitch shorter than half a bit is dropped
                    rx_state_next = rx_line ? ucip_pkg::RX_IDLE : ucip_pkg::RX_DATA;
                    rx_bit_next = 4'h0;
                end
                ucip_pkg::RX_DATA: begin
                    rx_shift_next = {rx_line, rx_shift_reg[7:1]};
                    rx_bit_next = rx_bit_reg + 4'h1;
                    if (rx_bit_reg == ucip_pkg::DATA_BITS - 4'h1) begin
                        rx_state_next = parity_on ? ucip_pkg::RX_PARITY
                            : ucip_pkg::RX_STOP;
                    end
                end
                ucip_pkg::RX_PARITY: begin
                    rx_state_next = ucip_pkg::RX_STOP;
                    rx_perr_next = rx_line != ucip_pkg::ucip_parity(rx_shift_reg,
                        even_parity_select);
                end
                ucip_pkg::RX_STOP: begin
                    rx_state_next = ucip_pkg::RX_IDLE;
                    rx_cnt_next = 12'h000;
                    rx_done = 1'b1;
                    rx_ferr = ~rx_line;
                    rx_brk = ~rx_line && rx_shift_reg == ucip_pkg::BYTE_ZERO
                        && (!parity_on || rx_perr_reg == ucip_pkg::ucip_parity(
                        ucip_pkg::BYTE_ZERO, ~even_parity_select));
                end
                default: rx_state_next = ucip_pkg::RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_reg <= ucip_pkg::RX_IDLE;
            rx_cnt_reg <= 12'h000;
            rx_bit_reg <= 4'h0;
            rx_shift_reg <= 8'h00;
            rx_perr_reg <= 1'b0;
        end else begin
            rx_state_reg <= rx_state_next;
            rx_cnt_reg <= rx_cnt_next;
            rx_bit_reg <= rx_bit_next;
            rx_shift_reg <= rx_shift_next;
            rx_perr_reg <= rx_perr_next;
        end
    end

endmodule

`default_nettype wire

// *** ucip_monitor.sv ***
// Port checker for the serial control slice
`timescale 1ns/1ps
`default_nettype none
module ucip_monitor (
    // APB side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Serial side and status
    input wire logic serial_tx_pin,
    input wire logic serial_rx_pin,
    input wire logic [4:0] tx_fifo_level,
    input wire logic [4:0] rx_fifo_level,
    input wire logic rx_timeout_pulse,
    input wire logic [6:0] irq_lines
);
    // ==================================================
    // Mask and loopback shadows, taken on the same write edge as the design
    logic [6:0] msk_reg, msk_next;
    logic loop_reg, loop_next;
    logic wr_go;
    assign wr_go = psel && penable && pwrite && pready;
    always_comb begin
        msk_next = (wr_go && paddr == ucip_pkg::OFF_MASK) ? pwdata[10:4] : msk_reg;
        loop_next = (wr_go && paddr == ucip_pkg::OFF_CTRL) ? pwdata[ucip_pkg::CTL_LOOP_BIT]
            : loop_reg;
    end
    // Shadow registers
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) {msk_reg, loop_reg} <= 8'h00;
        else {msk_reg, loop_reg} <= {msk_next, loop_next};
    // Level flags land one edge late, so a crossing is judged two samples back
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_mask_gate: assert property ((irq_lines & ~msk_reg) == 7'h00)
        else $error("unmasked line high");
    chk_reset_quiet: assert property ($rose(presetn) |-> irq_lines == 7'h00)
        else $error("lines not clear after reset");
    chk_rx_cross: assert property ($rose(irq_lines[0]) && $past(msk_reg[0])
        |-> $past(rx_fifo_level, 2) < $past(rx_fifo_level)) else $error("rx flag without rise");
    chk_tx_cross: assert property ($rose(irq_lines[1]) && $past(msk_reg[1])
        |-> $past(tx_fifo_level, 2) > $past(tx_fifo_level)) else $error("tx flag without fall");
    chk_rt_set: assert property (rx_timeout_pulse && msk_next[2] |=> irq_lines[2])
        else $error("timeout not raised");
    chk_rt_clear: assert property (wr_go && paddr == ucip_pkg::OFF_ICR && pwdata[6]
        && !rx_timeout_pulse |=> !irq_lines[2]) else $error("timeout not cleared");
    chk_loop_high: assert property (loop_reg |-> serial_tx_pin)
        else $error("pin low in loopback");
    chk_bit_hold: assert property ($fell(serial_tx_pin) |=> !serial_tx_pin [*8])
        else $error("low bit cut short");
endmodule
bind ucip_core ucip_monitor u_mon (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .serial_tx_pin, .serial_rx_pin, .tx_fifo_level, .rx_fifo_level,
    .rx_timeout_pulse, .irq_lines
);
`default_nettype wire

// *** ucip_remote.sv ***
// Remote serial transceiver model facing the slice's pins
`timescale 1ns/1ps
`default_nettype none
module ucip_remote (
    // Clock and pins
    input wire logic pclk,
    input wire logic serial_tx_pin,
    output logic serial_rx_pin
);
    // ==================================================
    // Line idles high; with parity on, a low stop bit is let go soon after mid-bit, as a pull-up would
    initial serial_rx_pin = 1'b1;
    task automatic send(input logic [7:0] d, input logic pon, input logic par, input logic stp);
        logic [10:0] f;
        f = pon ? {stp, par, d, 1'b0} : {1'b1, stp, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            serial_rx_pin <= f[i];
            repeat (ucip_pkg::HALF_BIT + 12'h010) @(posedge pclk);
            if (i == 10) serial_rx_pin <= 1'b1;
            repeat (ucip_pkg::BIT_CYCLES - ucip_pkg::HALF_BIT - 12'h010) @(posedge pclk);
        end
    endtask
    // Capture eleven bit times at mid-bit, start bit in bit 0
    task automatic grab(output logic [10:0] f);
        int k;
        f = 11'h000;
        for (k = 0; k < 20000 && serial_tx_pin !== 1'b0; k++) @(negedge pclk);
        repeat (ucip_pkg::HALF_BIT) @(negedge pclk);
        for (int i = 0; i < 11; i++) begin
            f[i] = serial_tx_pin;
            repeat (ucip_pkg::BIT_CYCLES) @(negedge pclk);
        end
    endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the serial control slice
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end
module tb_top;
    // ==================================================
    // Inputs start at rest; the level inputs stand in for the FIFOs
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rx_timeout_pulse = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [4:0] tx_fifo_level = 5'h00, rx_fifo_level = 5'h00;
    logic pready, pslverr, serial_tx_pin, serial_rx_pin;
    logic [6:0] irq_lines;
    logic [10:0] fr;
    int failures = 0, check_count = 0;
    int pts[5] = '{2, 4, 8, 12, 14};
    // Clock, design and far end
    always #20 pclk = ~pclk;
    ucip_core DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .serial_tx_pin, .serial_rx_pin, .tx_fifo_level, .rx_fifo_level,
        .rx_timeout_pulse, .irq_lines);
    ucip_remote rem (.pclk, .serial_tx_pin, .serial_rx_pin);
    task automatic wrap_up;
        if (failures == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One APB transfer; an idle edge first keeps strobes from being driven twice
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (k = 0; k < 50 && pready !== 1'b1; k++) @(posedge pclk);
        if (k == 50) begin failures++; wrap_up(); end
        q = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    // Reset values, write masks, unmapped space and loopback idle level
    task automatic t_regs;
        rd(ucip_pkg::OFF_CTRL, 32'h300);
        rd(ucip_pkg::OFF_TRIG, 32'h12);
        rd(ucip_pkg::OFF_MASK, 32'h0);
        wr(ucip_pkg::OFF_MASK, 32'hffff_ffff);
        rd(ucip_pkg::OFF_MASK, 32'h7f0);
        rd(12'hf00, 32'h0);
        `CHK(pslverr, 1'b1)
        wr(ucip_pkg::OFF_CTRL, 32'h381);
        `CHK(serial_tx_pin, 1'b1)
        wr(ucip_pkg::OFF_CTRL, 32'h300);
        wr(ucip_pkg::OFF_MASK, 32'h30);
    endtask
    // Each of the five valid trigger codes fires once on crossing, then stays quiet at that level
    task automatic t_trig;
        for (int c = 0; c < 5; c++) begin
            wr(ucip_pkg::OFF_TRIG, 32'(c * 9));
            {rx_fifo_level, tx_fifo_level} <= {5'(pts[c] - 1), 5'(pts[c] + 1)};
            wr(ucip_pkg::OFF_ICR, 32'h7f0);
            {rx_fifo_level, tx_fifo_level} <= {5'(pts[c]), 5'(pts[c])};
            repeat (3) @(negedge pclk);
            `CHK(irq_lines[1:0], 2'b11)
            wr(ucip_pkg::OFF_ICR, 32'h30);
            @(negedge pclk);
            `CHK(irq_lines[1:0], 2'b00)
        end
        // Reserved code must never fire, even with rx raised to full and tx dropped to empty
        wr(ucip_pkg::OFF_TRIG, 32'h2d);
        {rx_fifo_level, tx_fifo_level} <= {5'h10, 5'h00};
        repeat (3) @(negedge pclk);
        `CHK(irq_lines[1:0], 2'b00)
        wr(ucip_pkg::OFF_TRIG, 32'h24);
        wr(ucip_pkg::OFF_MASK, 32'h40);
        rx_fifo_level <= 5'h0d;
        wr(ucip_pkg::OFF_ICR, 32'h7f0);
        {rx_fifo_level, rx_timeout_pulse} <= {5'h0e, 1'b1};
        @(posedge pclk);
        rx_timeout_pulse <= 1'b0;
        @(negedge pclk);
        `CHK(irq_lines, 7'h04)
        wr(ucip_pkg::OFF_RAW, 32'h0);
        rd(ucip_pkg::OFF_RAW, 32'h50);
        rd(ucip_pkg::OFF_MIS, 32'h40);
        wr(ucip_pkg::OFF_ICR, 32'h40);
        rd(ucip_pkg::OFF_RAW, 32'h10);
    endtask
    // Frames in each parity mode; port held off while setting up
    task automatic t_tx;
        logic [7:0] d;
        logic [10:0] e;
        for (int m = 0; m < 3; m++) begin
            d = 8'ha5 ^ 8'(m);
            e = {2'b11, d, 1'b0};
            if (m > 0) e[9] = (m == 1) ? ^d : ~^d;
            wr(ucip_pkg::OFF_CTRL, 32'h300);
            wr(ucip_pkg::OFF_LINE_CTRL, (m == 0) ? 32'h4 : ((m == 1) ? 32'h6 : 32'h2));
            wr(ucip_pkg::OFF_DATA, {24'h0, d});
            repeat (300) @(posedge pclk);
            `CHK(serial_tx_pin, 1'b1)
            fork
                rem.grab(fr);
                wr(ucip_pkg::OFF_CTRL, 32'h301);
            join
            `CHK(fr, e)
        end
    endtask
    // Receive: good byte, parity fault, then framing fault
    task automatic t_rx;
        wr(ucip_pkg::OFF_ICR, 32'h7f0);
        rem.send(8'h3c, 1'b1, 1'b1, 1'b1);
        rd(ucip_pkg::OFF_DATA, 32'h3c);
        rd(ucip_pkg::OFF_RAW, 32'h0);
        rem.send(8'h3c, 1'b1, 1'b0, 1'b1);
        rd(ucip_pkg::OFF_RAW, 32'h100);
        rd(ucip_pkg::OFF_DATA, 32'h3c);
        rem.send(8'h3d, 1'b1, 1'b1, 1'b0);
        rd(ucip_pkg::OFF_RAW, 32'h180);
    endtask
    // Break held low for two character periods, then released with port off
    task automatic t_brk;
        wr(ucip_pkg::OFF_CTRL, 32'h300);
        wr(ucip_pkg::OFF_LINE_CTRL, 32'h1);
        wr(ucip_pkg::OFF_CTRL, 32'h301);
        repeat (4800) @(posedge pclk);
        `CHK(serial_tx_pin, 1'b0)
        wr(ucip_pkg::OFF_CTRL, 32'h300);
        wr(ucip_pkg::OFF_LINE_CTRL, 32'h0);
        // The line register needs one more edge after the write lands
        repeat (2) @(negedge pclk);
        `CHK(serial_tx_pin, 1'b1)
    endtask
    // Main sequence and hang guard
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_trig();
        t_tx();
        t_rx();
        t_brk();
        wrap_up();
    end
    initial begin
        repeat (60000) @(posedge pclk);
        failures++;
        wrap_up();
    end
endmodule
`default_nettype wire
